// ===== logic/dpt_defs.svh
`ifndef DPT_DEFS_SVH
`define DPT_DEFS_SVH

// Register addresses (8-bit register space)
`define DPT_ADDR_MODE 8'hf1
`define DPT_ADDR_CNT1 8'hf2
`define DPT_ADDR_PRE1 8'hf3
`define DPT_ADDR_CNT0 8'hf4
`define DPT_ADDR_PRE0 8'hf5
`define DPT_ADDR_IRQ_STAT 8'he0
`define DPT_ADDR_IRQ_CLR 8'he1
`define DPT_ADDR_IRQ_EN 8'he2
`define DPT_ADDR_OPTION 8'he3

// Mode register fields
`define DPT_MODE_LOAD0 0
`define DPT_MODE_RUN0 1
`define DPT_MODE_LOAD1 2
`define DPT_MODE_RUN1 3
`define DPT_MODE_PIN_LO 4
`define DPT_MODE_PIN_HI 5
`define DPT_MODE_RESET 8'h00

// Prescaler setup fields
`define DPT_PRE_MODULO 0
`define DPT_PRE_CLKSEL 1
`define DPT_PRE_DIV_LO 2
`define DPT_PRE_DIV_HI 7
`define DPT_PRE_RESET 8'h00

// Option register: bit 0 selects the low-emission option
`define DPT_OPT_LOWEMI 0

// Clock: 10 MHz core clock, 100 ns period
`define DPT_CLK_PERIOD_NS 100
// Low-emission timer clock at most 4 MHz: 250 ns least period
`define DPT_LOWEMI_PERIOD_NS 250
`define DPT_LOWEMI_CYCLES ((`DPT_LOWEMI_PERIOD_NS + `DPT_CLK_PERIOD_NS - 1) / `DPT_CLK_PERIOD_NS)
// Internal timer tick is the processor clock divided by four
`define DPT_INT_DIV 4
// Standard mode divides the oscillator by two
`define DPT_STD_DIV 2

`endif

// ===== logic/dpt_pkg.sv
package dpt_pkg;
  typedef enum logic [1:0] {
    DPT_PIN_CLOCK = 2'b00,
    DPT_PIN_TRIG_RETRIG = 2'b01,
    DPT_PIN_TRIG_ONCE = 2'b11,
    DPT_PIN_GATE = 2'b10
  } dpt_pin_e;
endpackage

// ===== logic/dpt_tick_gen.sv
`timescale 1ns/100ps
`include "dpt_defs.svh"
// Internal timer tick: core clock divided by DIV in standard mode, by
// LE_DIV when the low-emission option bypasses the divide-by-two stage.
module dpt_tick_gen #(
  parameter int DIV = `DPT_INT_DIV * `DPT_STD_DIV,
  parameter int LE_DIV = `DPT_INT_DIV * `DPT_LOWEMI_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_low_emi,
  output logic o_tick
);
  logic [7:0] div_reg;
  logic [7:0] limit;

  assign limit = i_low_emi ? 8'(LE_DIV - 1) : 8'(DIV - 1);

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      div_reg <= 8'h00;
      o_tick <= 1'b0;
    end else if (div_reg >= limit) begin
      div_reg <= 8'h00;
      o_tick <= 1'b1;
    end else begin
      div_reg <= div_reg + 8'h01;
      o_tick <= 1'b0;
    end
  end
endmodule

// ===== logic/dpt_channel.sv
`timescale 1ns/100ps
`include "dpt_defs.svh"
// One prescaler plus 8-bit down counter.
module dpt_channel #(
  parameter int CW = 8,
  parameter int PW = 6
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_src_tick,
  input wire logic i_qualify,
  input wire logic i_load,
  input wire logic i_run,
  input wire logic i_modulo,
  input wire logic [PW-1:0] i_div,
  input wire logic [CW-1:0] i_init,
  output logic [CW-1:0] o_count,
  output logic o_running,
  output logic o_end
);
  logic [PW-1:0] pre_reg;
  logic pre_end;

  // A field of zero wraps through 63 and so divides by 64; a zero count loaded while i_run is high means 256
  assign pre_end = (pre_reg == PW'(1));

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pre_reg <= '0;
      o_count <= '0;
      o_running <= 1'b0;
      o_end <= 1'b0;
    end else begin
      o_end <= 1'b0;
      if (i_load) begin
        pre_reg <= i_div;
        o_count <= i_init;
        o_running <= i_run;
      end else begin
        o_running <= i_run && o_running | (i_run && !o_running && o_count != '0);
        if (o_running && i_run && i_src_tick && i_qualify) begin
          if (!pre_end) begin
            pre_reg <= pre_reg - PW'(1);
          end else begin
            pre_reg <= i_div;
            o_count <= o_count - CW'(1);
            if (o_count == CW'(1)) begin
              o_end <= 1'b1;
              if (i_modulo) begin
                o_count <= i_init;
              end else begin
                o_running <= 1'b0;
              end
            end
          end
        end
      end
    end
  end
endmodule

// ===== logic/dpt_timer.sv
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
`include "dpt_defs.svh"
// Functional notes
// [RULE1] Two independent 8-bit down counters, each behind its own 6-bit prescaler.
// [RULE2] The first prescaler uses only the internal clock; the second may use the pin.
// [RULE3] Each prescaler divides its source by 1 to 64 before stepping its counter.
// [RULE4] Each counter steps down once per prescaler pulse from a loaded count of 1 to 256; a zero loaded by the write that sets the run bit never starts.
// [RULE5] When counter and prescaler both end, that timer's interrupt request is raised.
// [RULE6] Software may start, stop, continue from the current count or restart from the load.
// [RULE7] Single-pass mode halts at zero; modulo mode reloads and keeps counting.
// [RULE8] Counter reads return the live count without side effects; prescalers read as zero.
// [RULE9] The second timer counts the internal clock divided by four or the external pin.
// [RULE10] The pin works as clock, retriggerable trigger, one-shot trigger or gate.
// [RULE11] Timers and their requests keep running while the processor clock is halted.
// [RULE12] Counter writes set the initial count; prescaler writes set divide, source and mode.
// [RULE13] Low-emission option caps the timer clock at 4 MHz and bypasses the divide-by-two.
module dpt_timer
  import dpt_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_ext_pin,
  output logic [7:0] o_rdata,
  output logic o_first_timer_request,
  output logic o_second_timer_request,
  output logic o_irq
);
  logic [7:0] mode_reg;
  logic [7:0] pre0_reg;
  logic [7:0] pre1_reg;
  logic [7:0] init0_reg;
  logic [7:0] init1_reg;
  logic [1:0] stat_reg;
  logic [1:0] en_reg;
  logic opt_reg;
  logic pin_m_reg;
  logic pin_s_reg;
  logic pin_d_reg;
  logic trig_seen_reg;
  logic tick;
  logic pin_rise;
  logic pin_fall;
  logic [7:0] cnt0;
  logic [7:0] cnt1;
  logic run0;
  logic run1;
  logic end0;
  logic end1;
  logic load0;
  logic load1;
  logic src1_tick;
  logic qual1;
  logic trig_load;
  logic [7:0] rdata_next;
  dpt_pin_e pin_mode;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  assign pin_mode = dpt_pin_e'(mode_reg[`DPT_MODE_PIN_HI:`DPT_MODE_PIN_LO]);

  // Software register writes
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      mode_reg <= `DPT_MODE_RESET;
      pre0_reg <= `DPT_PRE_RESET;
      pre1_reg <= `DPT_PRE_RESET;
      init0_reg <= 8'h00;
      init1_reg <= 8'h00;
      en_reg <= 2'b00;
      opt_reg <= 1'b0;
    end else if (i_wr) begin
      if (hit(i_addr, `DPT_ADDR_MODE)) begin
        mode_reg <= i_wdata & 8'h3f; // see [RULE6] [RULE10]
      end
      if (hit(i_addr, `DPT_ADDR_CNT0)) begin
        init0_reg <= i_wdata; // see [RULE12]
      end
      if (hit(i_addr, `DPT_ADDR_CNT1)) begin
        init1_reg <= i_wdata; // see [RULE12]
      end
      if (hit(i_addr, `DPT_ADDR_PRE0)) begin
        pre0_reg <= i_wdata & 8'hfd; // see [RULE2] [RULE12]
      end
      if (hit(i_addr, `DPT_ADDR_PRE1)) begin
        pre1_reg <= i_wdata; // see [RULE12]
      end
      if (hit(i_addr, `DPT_ADDR_IRQ_EN)) begin
        en_reg <= i_wdata[1:0];
      end
      if (hit(i_addr, `DPT_ADDR_OPTION)) begin
        opt_reg <= i_wdata[`DPT_OPT_LOWEMI];
      end
    end
  end

  // Load bits are self-clearing one-cycle pulses from the write
  assign load0 = i_wr && hit(i_addr, `DPT_ADDR_MODE) && i_wdata[`DPT_MODE_LOAD0]; // see [RULE6]
  assign load1 = (i_wr && hit(i_addr, `DPT_ADDR_MODE) && i_wdata[`DPT_MODE_LOAD1])
                 || trig_load; // see [RULE6] [RULE10]

  // Pin synchroniser; the second stage and its delayed copy (pin_d_reg) feed logic
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pin_m_reg <= 1'b0;
      pin_s_reg <= 1'b0;
      pin_d_reg <= 1'b0;
    end else begin
      pin_m_reg <= i_ext_pin;
      pin_s_reg <= pin_m_reg;
      pin_d_reg <= pin_s_reg;
    end
  end
  assign pin_rise = pin_s_reg && !pin_d_reg;
  assign pin_fall = !pin_s_reg && pin_d_reg;

  dpt_tick_gen u_tick (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_low_emi(opt_reg), // see [RULE13]
    .o_tick(tick)
  );

  // Trigger handling: a falling edge reloads the second timer
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      trig_seen_reg <= 1'b0;
    end else if (load1 && !trig_load) begin
      trig_seen_reg <= 1'b0;
    end else if (trig_load) begin
      trig_seen_reg <= 1'b1;
    end
  end
  assign trig_load = mode_reg[`DPT_MODE_RUN1] && pin_fall &&
                     ((pin_mode == DPT_PIN_TRIG_RETRIG) ||
                      (pin_mode == DPT_PIN_TRIG_ONCE && !trig_seen_reg)); // see [RULE10]

  // Source and qualifier for the second timer
  always_comb begin
    src1_tick = tick; // see [RULE9]
    qual1 = 1'b1;
    if (pre1_reg[`DPT_PRE_CLKSEL]) begin
      unique case (pin_mode)
        DPT_PIN_CLOCK: src1_tick = pin_fall; // see [RULE9] [RULE10]
        DPT_PIN_GATE: qual1 = pin_s_reg; // see [RULE10]
        DPT_PIN_TRIG_RETRIG, DPT_PIN_TRIG_ONCE: qual1 = trig_seen_reg; // see [RULE10]
      endcase
    end
  end

  // Both channels run from the core clock, independent of processor halt
  dpt_channel u_ch0 ( // see [RULE1] [RULE11]
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_src_tick(tick), // see [RULE2]
    .i_qualify(1'b1),
    .i_load(load0),
    .i_run(mode_reg[`DPT_MODE_RUN0]),
    .i_modulo(pre0_reg[`DPT_PRE_MODULO]), // see [RULE7]
    .i_div(pre0_reg[`DPT_PRE_DIV_HI:`DPT_PRE_DIV_LO]), // see [RULE3]
    .i_init(init0_reg), // see [RULE4]
    .o_count(cnt0),
    .o_running(run0),
    .o_end(end0)
  );

  dpt_channel u_ch1 ( // see [RULE1] [RULE11]
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_src_tick(src1_tick),
    .i_qualify(qual1),
    .i_load(load1),
    .i_run(mode_reg[`DPT_MODE_RUN1]),
    .i_modulo(pre1_reg[`DPT_PRE_MODULO]), // see [RULE7]
    .i_div(pre1_reg[`DPT_PRE_DIV_HI:`DPT_PRE_DIV_LO]), // see [RULE3]
    .i_init(init1_reg), // see [RULE4]
    .o_count(cnt1),
    .o_running(run1),
    .o_end(end1)
  );

  // Sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      stat_reg <= 2'b00;
    end else begin
      stat_reg <= (stat_reg & ~((i_wr && hit(i_addr, `DPT_ADDR_IRQ_CLR)) ?
                   i_wdata[1:0] : 2'b00)) | {end1, end0}; // see [RULE5]
    end
  end

  // Request pulses mark each end of count directly
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_first_timer_request <= 1'b0;
      o_second_timer_request <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      o_first_timer_request <= end0; // see [RULE5] [RULE11]
      o_second_timer_request <= end1; // see [RULE5] [RULE11]
      o_irq <= |((stat_reg | {end1, end0}) & en_reg);
    end
  end

  // Read mux; prescalers and the clear register read as zero
  always_comb begin
    rdata_next = 8'h00;
    unique case (i_addr)
      `DPT_ADDR_MODE: rdata_next = {2'b00, mode_reg[5:4], run1, 1'b0, run0, 1'b0};
      `DPT_ADDR_CNT0: rdata_next = cnt0; // see [RULE8]
      `DPT_ADDR_CNT1: rdata_next = cnt1; // see [RULE8]
      `DPT_ADDR_IRQ_STAT: rdata_next = {6'h00, stat_reg};
      `DPT_ADDR_IRQ_EN: rdata_next = {6'h00, en_reg};
      `DPT_ADDR_OPTION: rdata_next = {7'h00, opt_reg};
      default: rdata_next = 8'h00; // see [RULE8]
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= rdata_next;
    end else begin
      o_rdata <= 8'h00;
    end
  end
endmodule

// ===== bench/dpt_timer_monitor.sv
`timescale 1ns/100ps
module dpt_timer_monitor (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_ext_pin,
  input wire logic [7:0] o_rdata,
  input wire logic o_first_timer_request,
  input wire logic o_second_timer_request,
  input wire logic o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  logic rq;
  assign rq = o_first_timer_request || o_second_timer_request;
  a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside its slot");
  a_pre_read_hidden: assert property (
    $past(i_rd) && ($past(i_addr) inside {8'hf3, 8'hf5}) |-> o_rdata == 8'h00)
    else $error("prescaler read not zero");
  a_req0_min_gap: assert property (
    o_first_timer_request |=> !o_first_timer_request [*7])
    else $error("first request too soon");
  a_req1_min_gap: assert property (
    o_second_timer_request |=> !o_second_timer_request [*7])
    else $error("second request too soon");
  a_irq_rise_cause: assert property (
    $rose(o_irq) |-> rq || $past(rq) || $past(rq, 2) || $past(i_wr) || $past(i_wr, 2))
    else $error("irq rose without cause");
  a_irq_fall_cause: assert property (
    $fell(o_irq) && $past(i_rst_b) |-> $past(i_wr) || $past(i_wr, 2))
    else $error("irq fell without write");
  a_irq_sticky_hold: assert property (o_irq && !i_wr && !$past(i_wr) |=> o_irq)
    else $error("irq dropped on its own");
  a_reset_quiet_start: assert property ($rose(i_rst_b) |-> (!rq && !o_irq) [*8])
    else $error("activity right after reset");
  c_first_req: cover property (o_first_timer_request);
  c_second_req: cover property (o_second_timer_request);
  c_irq_rise: cover property ($rose(o_irq));
endmodule

// ===== bench/dual_prescaled_countdown_timer_tb_top.sv
`timescale 1ns/100ps
module dual_prescaled_countdown_timer_tb_top import dpt_pkg::*; ;
  logic i_clk = 1'h0, i_rst_b = 1'h0, i_wr = 1'h0, i_rd = 1'h0, i_ext_pin = 1'h0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata, rv, sv;
  logic o_first_timer_request, o_second_timer_request, o_irq;
  int n_fail = 0, checks_done = 0, cyc = 0, n0 = 0, n1 = 0, t0 = 0, c, k;
  dpt_timer u_dut (.i_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd, .i_ext_pin,
    .o_rdata, .o_first_timer_request, .o_second_timer_request, .o_irq);
  initial forever #50 i_clk = ~i_clk;
  // Requests are one-cycle pulses, so count them here rather than in the tests
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (o_first_timer_request === 1'h1) begin
      n0 <= n0 + 1;
      t0 <= cyc;
    end
    if (o_second_timer_request === 1'h1) n1 <= n1 + 1;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic step(int m);
    repeat (m) @(posedge i_clk);
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'h1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'h0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge i_clk);
    i_rd <= 1'h1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'h0;
    #1 rv = o_rdata;
  endtask
  task automatic chk8(logic [7:0] g, logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t: value %h not %h", $time, g, e);
    end
  endtask
  task automatic chkn(int g, int lo, int hi);
    checks_done++;
    if (g < lo || g > hi) begin
      n_fail++;
      $display("mismatch at %0t: count %0d not in %0d..%0d", $time, g, lo, hi);
    end
  endtask
  task automatic wt0(int e);
    int m;
    m = 0;
    while (n0 < e && m < 200) begin
      @(posedge i_clk);
      #1 m++;
    end
    if (n0 < e) begin
      n_fail++;
      $display("mismatch at %0t: first timer request never came", $time);
      tally_and_finish();
    end
  endtask
  // Pin high then low, each long enough for the two-flop synchroniser
  task automatic fall;
    i_ext_pin <= 1'h1;
    step(8);
    i_ext_pin <= 1'h0;
    step(8);
  endtask
  task automatic t_reset;
    logic [7:0] al [7] = '{8'hf1, 8'hf2, 8'hf3, 8'hf4, 8'hf5, 8'h10, 8'he0};
    foreach (al[i]) begin
      rd(al[i]);
      chk8(rv, 8'h00);
    end
    $display("reset test done");
  endtask
  task automatic t_single;
    wr(8'hf5, 8'h04);
    rd(8'hf5);
    chk8(rv, 8'h00);
    wr(8'hf4, 8'h03);
    k = n0;
    c = cyc;
    wr(8'hf1, 8'h03);
    wt0(k + 1);
    chkn(t0 - c, 16, 32);
    step(40);
    chkn(n0, k + 1, k + 1);
    rd(8'hf4);
    chk8(rv, 8'h00);
    rd(8'hf1);
    chk8(rv, 8'h00);
    $display("single pass test done");
  endtask
  task automatic t_modulo;
    wr(8'hf5, 8'h09);
    wr(8'hf4, 8'h02);
    wr(8'hf1, 8'h03);
    for (int le = 0; le < 2; le++) begin
      wr(8'he3, le[7:0]);
      wt0(n0 + 2);
      c = t0;
      wt0(n0 + 1);
      chkn(t0 - c, 32 + 16 * le, 32 + 16 * le);
    end
    wr(8'he3, 8'h00);
    wr(8'hf1, 8'h00);
    // An end of count at the stop edge still reaches the request pin
    step(3);
    k = n0;
    rd(8'hf4);
    sv = rv;
    step(40);
    rd(8'hf4);
    chk8(rv, sv);
    chkn(n0, k, k);
    wr(8'hf1, 8'h02);
    wt0(k + 1);
    chkn(n0, k + 1, k + 1);
    $display("modulo test done");
  endtask
  task automatic t_irq;
    // Drop status left by earlier tests so the level must come from a new event
    wr(8'he1, 8'h03);
    wr(8'he2, 8'h01);
    wt0(n0 + 1);
    step(3);
    chk8(o_irq, 1'h1);
    rd(8'he0);
    chk8(rv, 8'h01);
    wr(8'he1, 8'h01);
    step(2);
    chk8(o_irq, 1'h0);
    wr(8'he2, 8'h00);
    wt0(n0 + 1);
    step(3);
    chk8(o_irq, 1'h0);
    rd(8'he0);
    chk8(rv, 8'h01);
    wr(8'hf1, 8'h00);
    wr(8'he1, 8'h03);
    $display("interrupt test done");
  endtask
  task automatic t_pin;
    wr(8'hf3, 8'h06);
    wr(8'hf2, 8'h02);
    wr(8'hf1, 8'h0c);
    k = n1;
    fall();
    step(30);
    chkn(n1, k, k);
    fall();
    step(6);
    chkn(n1, k + 1, k + 1);
    $display("pin clock test done");
  endtask
  task automatic t_trig;
    dpt_pin_e ml [2] = '{DPT_PIN_TRIG_RETRIG, DPT_PIN_TRIG_ONCE};
    foreach (ml[i]) begin
      // Pin source selected and run bit set: the trigger only arms a running timer
      wr(8'hf3, 8'h06);
      wr(8'hf2, 8'h02);
      wr(8'hf1, {2'h0, ml[i], 4'hc});
      k = n1;
      step(40);
      chkn(n1, k, k);
      fall();
      step(30);
      chkn(n1, k + 1, k + 1);
      fall();
      step(30);
      chkn(n1, k + 2 - i, k + 2 - i);
    end
    wr(8'hf1, {2'h0, DPT_PIN_GATE, 4'hc});
    k = n1;
    step(40);
    chkn(n1, k, k);
    i_ext_pin <= 1'h1;
    step(30);
    chkn(n1, k + 1, k + 1);
    i_ext_pin <= 1'h0;
    $display("trigger and gate test done");
  endtask
  initial begin
    step(3);
    i_rst_b <= 1'h1;
    t_reset();
    t_single();
    t_modulo();
    t_irq();
    t_pin();
    t_trig();
    tally_and_finish();
  end
endmodule
bind dpt_timer dpt_timer_monitor u_mon (.i_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd,
  .i_ext_pin, .o_rdata, .o_first_timer_request, .o_second_timer_request, .o_irq);
